// ### include/wpr_pkg.sv
// Purpose: Shared constants and types for the watchdog, power and reset control block.
// Assumes: One 25 MHz clock that stands for the oscillator; APB register access.
// Notes: Function
// Function
// - Select code doubles divisor; timeout after 2^14 prescaled machine cycles.
// - Restart bit clears timer, prescaler, itself next cycle; the code waits for the end of the machine cycle instead.
// - System reset clears the watchdog timer count.
// - Oscillator divided by two for internal clock.
// - Light sleep stops processor, peripherals keep clock.
// - Interrupt or reset ends light sleep.
// - Deep sleep stops every clock and oscillator.
// - Only reset ends deep sleep, never interrupts.
// - Reset pin sampled at state5_phase2, two cycles.
// - Short glitches on reset pin are ignored.
// - Reset loads FFH ports, 07H stack, zeroed registers.
// - Enabled watchdog counts; time-out causes system reset.
// - Watchdog stays disabled after reset until enabled.
// - Watchdog runs in light sleep only if allowed.
// - Cold boot flag set by power-on reset only; the code also sets it on an APB write of 1 to bit 4 of power_ctl_reg.
package wpr_pkg;
   // Register byte offsets on the APB.
   localparam logic [7:0] ADDR_WDOG = 8'h00;
   localparam logic [7:0] ADDR_PWR = 8'h04;
   localparam logic [7:0] ADDR_STAT = 8'h08;
   localparam logic [7:0] ADDR_MASK = 8'h0C;
   localparam logic [7:0] ADDR_COUNT = 8'h10;
   // Field positions in watchdog_control_reg.
   localparam int WD_RUN_BIT = 7;
   localparam int WD_RESTART_BIT = 6;
   localparam int WD_SLEEP_BIT = 5;
   // Field positions in power_ctl_reg.
   localparam int PWR_COLD_BIT = 4;
   localparam int PWR_GF_LSB = 2;
   localparam int PWR_DEEP_BIT = 1;
   localparam int PWR_LIGHT_BIT = 0;
   // Values loaded by a system reset.
   localparam logic [7:0] PORT_RST = 8'hFF;
   localparam logic [7:0] SP_RST = 8'h07;
   // Cycle counts: two oscillator clocks per state, six states per machine cycle.
   localparam logic [2:0] MC_LAST = 3'h5;
   localparam logic [2:0] MC_SAMPLE_STATE = 3'h4;
   localparam logic [1:0] RST_HOLD_MC = 2'h2;
   localparam int EXT_RST_SAMPLES = 2;
   localparam int GLITCH_TAPS = 3;
   localparam int TIMER_W = 14;
   localparam int PRESC_W = 8;
   // Event bits of the interrupt status register.
   localparam int EV_TIMEOUT = 0;
   localparam int EV_EXTRST = 1;
   localparam int EV_WAKE = 2;
   localparam int EV_W = 3;
   // Power modes, Gray coded along run, light, deep.
   typedef enum logic [1:0] {
      WPR_RUN = 2'b00,
      WPR_LIGHT = 2'b01,
      WPR_DEEP = 2'b11
   } wpr_mode_t;
   // APB request from the master.
   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [7:0] paddr;
      logic [31:0] pwdata;
   } wpr_apb_req_t;
   // APB answer to the master.
   typedef struct packed {
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } wpr_apb_rsp_t;
   // Clock gating enables handed to the rest of the chip.
   typedef struct packed {
      logic cpu_clk_en;
      logic per_clk_en;
      logic osc_run;
   } wpr_pwr_t;
   // Whole state of the main module.
   typedef struct packed {
      wpr_mode_t mode;
      logic ph;
      logic [2:0] mc_st;
      logic wd_run;
      logic wd_restart;
      logic wd_sleep;
      logic [2:0] wd_sel;
      logic [1:0] gflags;
      logic cold;
      logic [PRESC_W-1:0] presc;
      logic [TIMER_W-1:0] wtimer;
      logic [1:0] hold;
      logic sys_rst;
      logic ext_d;
      logic [EV_W-1:0] stat;
      logic [EV_W-1:0] mask;
      logic irq;
      wpr_apb_rsp_t rsp;
      wpr_pwr_t pwr;
      logic [7:0] port_val;
      logic [7:0] sp_val;
   } wpr_state_t;
   // Whole state of the reset pin filter.
   typedef struct packed {
      logic [GLITCH_TAPS-1:0] taps;
      logic [1:0] cnt;
      logic seen;
   } wpr_filt_t;
endpackage

// ### rtl/wpr_rst_filt.sv
// Purpose: Deglitch and sample the external reset pin.
// Assumes: Pin is synchronous to clk; sample strobe comes once per machine cycle.
// Notes: The output is a level that stays high while the pin stays high.
`timescale 1ns/1ps
module wpr_rst_filt (
   input wire logic clk,
   input wire logic reset,
   input wire logic ext_rst,
   input wire logic sample_stb,
   output logic rst_seen
);
   wpr_pkg::wpr_filt_t q;
   wpr_pkg::wpr_filt_t n;
   logic clean;

   // The pin counts as high only when every tap agrees, so a short pulse is lost.
   always_comb begin
      n = q;
      n.taps = {q.taps[wpr_pkg::GLITCH_TAPS-2:0], ext_rst};
      clean = &q.taps;
      if (sample_stb) begin
         // A low sample restarts the count; two high samples in a row are needed.
         if (!clean) begin
            n.cnt = 2'h0;
         end else if (q.cnt != 2'(wpr_pkg::EXT_RST_SAMPLES)) begin
            n.cnt = q.cnt + 2'h1;
         end
      end
      n.seen = (n.cnt == 2'(wpr_pkg::EXT_RST_SAMPLES));
   end

   // State register.
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         q <= '0;
      end else begin
         q <= n;
      end
   end

   assign rst_seen = q.seen;

   AST_PIN_SAMPLED: assert property (@(posedge clk) disable iff (reset)
      $rose(q.seen) |-> $past(sample_stb) && $past(q.cnt) == 2'h1)
      else $error("Reset pin accepted off the sample point or too early.");
   AST_PIN_CLEAN: assert property (@(posedge clk) disable iff (reset)
      $rose(q.seen) |-> $past(clean))
      else $error("Reset accepted from a glitchy pin level.");
endmodule

// ### rtl/wpr_top.sv
// Purpose: Watchdog, light and deep sleep control, and reset generation.
// Assumes: clk is the oscillator; reset is the power-on reset; APB slave.
// Notes: The timing chain keeps running in deep sleep only to sample the reset pin.
`timescale 1ns/1ps
module wpr_top (
   input wire logic clk,
   input wire logic reset,
   input wire wpr_pkg::wpr_apb_req_t apb_req,
   output wpr_pkg::wpr_apb_rsp_t apb_rsp,
   input wire logic ext_rst,
   input wire logic irq_wake,
   output wpr_pkg::wpr_pwr_t pwr,
   output logic sys_reset,
   output logic irq,
   output logic [7:0] port_init_val,
   output logic [7:0] sp_init_val
);
   localparam int EV_W_LOCAL = wpr_pkg::EV_W; // Width of the event vector.
   wpr_pkg::wpr_state_t q; // Current state.
   wpr_pkg::wpr_state_t n; // Next state.
   logic rst_seen; // Filtered reset pin level.
   logic int_en; // Internal clock enable, half the oscillator rate.
   logic state5_phase2; // The state5_phase2 strobe.
   logic mc_end; // Last clock of a machine cycle.
   logic wd_go; // Watchdog allowed to count.
   logic [8:0] div; // Prescaler divisor.
   logic [8:0] div_m1; // Divisor minus one.
   logic tick; // Prescaler wraps this cycle.
   logic timeout; // Watchdog expires this cycle.
   logic access; // APB access phase.
   logic done; // APB transfer completes at this edge.
   logic hit; // Address is mapped.
   logic wr; // A write takes effect.
   logic [EV_W_LOCAL-1:0] ev; // Events seen this cycle.
   logic [31:0] rdata; // Read data mux.

   // The reset pin filter samples at state5_phase2.
   wpr_rst_filt u_filt (
      .clk(clk),
      .reset(reset),
      .ext_rst(ext_rst),
      .sample_stb(state5_phase2),
      .rst_seen(rst_seen)
   );

   // Decoding of the address and read data, kept apart from the state update.
   always_comb begin
      hit = 1'b1;
      rdata = 32'h0000_0000;
      case (apb_req.paddr)
         wpr_pkg::ADDR_WDOG: begin
            rdata[7:0] = {q.wd_run, q.wd_restart, q.wd_sleep, 2'b00, q.wd_sel};
         end
         wpr_pkg::ADDR_PWR: begin
            rdata[7:0] = {3'b000, q.cold, q.gflags, q.mode == wpr_pkg::WPR_DEEP,
                          q.mode == wpr_pkg::WPR_LIGHT};
         end
         wpr_pkg::ADDR_STAT: begin
            rdata[EV_W_LOCAL-1:0] = q.stat;
         end
         wpr_pkg::ADDR_MASK: begin
            rdata[EV_W_LOCAL-1:0] = q.mask;
         end
         wpr_pkg::ADDR_COUNT: begin
            rdata[wpr_pkg::TIMER_W-1:0] = q.wtimer;
         end
         default: begin
            hit = 1'b0;
         end
      endcase
   end

   // Timing chain, watchdog, power modes, registers and interrupt in one update.
   always_comb begin
      n = q;
      ev = '0;
      // The oscillator is halved; a machine cycle is six internal states.
      n.ph = ~q.ph;
      int_en = q.ph;
      mc_end = int_en && (q.mc_st == wpr_pkg::MC_LAST);
      state5_phase2 = int_en && (q.mc_st == wpr_pkg::MC_SAMPLE_STATE);
      if (int_en) begin
         n.mc_st = (q.mc_st == wpr_pkg::MC_LAST) ? 3'h0 : q.mc_st + 3'h1;
      end

      // The select code gives a divisor of 2 to 256 in powers of two.
      div = 9'h002 << q.wd_sel;
      div_m1 = div - 9'h001;
      // Counting needs the enable; light sleep also needs its own permission.
      wd_go = q.wd_run && ((q.mode == wpr_pkg::WPR_RUN) ||
              ((q.mode == wpr_pkg::WPR_LIGHT) && q.wd_sleep));
      tick = wd_go && mc_end && (q.presc == div_m1[wpr_pkg::PRESC_W-1:0]);
      timeout = tick && (&q.wtimer) && !q.wd_restart;

      if (q.wd_restart) begin
         // A restart request waits for the end of the current machine cycle.
         if (mc_end) begin
            n.presc = '0;
            n.wtimer = '0;
            n.wd_restart = 1'b0;
         end
      end else if (wd_go && mc_end) begin
         if (tick) begin
            n.presc = '0;
            n.wtimer = q.wtimer + 14'h0001;
         end else begin
            n.presc = q.presc + 8'h01;
         end
      end

      // A time-out holds the internal reset for whole machine cycles.
      if (timeout) begin
         n.hold = wpr_pkg::RST_HOLD_MC;
         ev[wpr_pkg::EV_TIMEOUT] = 1'b1;
      end else if (mc_end && (q.hold != 2'h0)) begin
         n.hold = q.hold - 2'h1;
      end

      // An interrupt ends light sleep; deep sleep ignores it.
      if ((q.mode == wpr_pkg::WPR_LIGHT) && irq_wake) begin
         n.mode = wpr_pkg::WPR_RUN;
         ev[wpr_pkg::EV_WAKE] = 1'b1;
      end

      // APB: one wait state, the answer is registered.
      access = apb_req.psel && apb_req.penable;
      done = access && q.rsp.pready;
      wr = done && apb_req.pwrite && hit;
      n.rsp.pready = access && !q.rsp.pready;
      n.rsp.pslverr = access && !q.rsp.pready && !hit;
      n.rsp.prdata = (access && !q.rsp.pready && !apb_req.pwrite) ? rdata : 32'h0000_0000;
      if (wr) begin
         case (apb_req.paddr)
            wpr_pkg::ADDR_WDOG: begin
               n.wd_run = apb_req.pwdata[wpr_pkg::WD_RUN_BIT];
               n.wd_sleep = apb_req.pwdata[wpr_pkg::WD_SLEEP_BIT];
               n.wd_sel = apb_req.pwdata[2:0];
               // Writing zero never cancels a pending restart.
               n.wd_restart = q.wd_restart | apb_req.pwdata[wpr_pkg::WD_RESTART_BIT];
            end
            wpr_pkg::ADDR_PWR: begin
               n.cold = apb_req.pwdata[wpr_pkg::PWR_COLD_BIT];
               n.gflags = apb_req.pwdata[wpr_pkg::PWR_GF_LSB +: 2];
               // Deep sleep wins when both sleep bits are written together.
               // Once in deep sleep no write may leave it; only a reset does.
               if (apb_req.pwdata[wpr_pkg::PWR_DEEP_BIT]) begin
                  n.mode = wpr_pkg::WPR_DEEP;
               end else if (apb_req.pwdata[wpr_pkg::PWR_LIGHT_BIT] &&
                            (q.mode != wpr_pkg::WPR_DEEP)) begin
                  n.mode = wpr_pkg::WPR_LIGHT;
               end
            end
            wpr_pkg::ADDR_MASK: begin
               n.mask = apb_req.pwdata[EV_W_LOCAL-1:0];
            end
            default: begin
               n.mask = n.mask;
            end
         endcase
      end

      // A system reset loads the documented values; the cold boot flag is kept.
      if (q.sys_rst) begin
         n.wd_run = 1'b0;
         n.wd_restart = 1'b0;
         n.wd_sleep = 1'b0;
         n.wd_sel = 3'h0;
         n.presc = '0;
         n.wtimer = '0;
         n.gflags = 2'h0;
         n.mode = wpr_pkg::WPR_RUN;
         n.port_val = wpr_pkg::PORT_RST;
         n.sp_val = wpr_pkg::SP_RST;
      end

      // The internal reset follows the pin filter or the time-out hold.
      n.ext_d = rst_seen;
      ev[wpr_pkg::EV_EXTRST] = rst_seen && !q.ext_d;
      n.sys_rst = rst_seen || (n.hold != 2'h0);

      // Sticky events: a set in the clearing cycle survives.
      n.stat = q.stat & ~((done && apb_req.pwrite && (apb_req.paddr == wpr_pkg::ADDR_STAT))
               ? apb_req.pwdata[EV_W_LOCAL-1:0] : '0);
      n.stat = n.stat | ev;
      n.irq = |(n.stat & n.mask);

      // Clock enables pulse at the internal rate and follow the new mode.
      n.pwr.cpu_clk_en = n.ph && (n.mode == wpr_pkg::WPR_RUN) && !n.sys_rst;
      n.pwr.per_clk_en = n.ph && (n.mode != wpr_pkg::WPR_DEEP);
      n.pwr.osc_run = (n.mode != wpr_pkg::WPR_DEEP);
   end

   // State register; the power-on reset sets the cold boot flag, and an APB write to the power register can also set it.
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         q <= '0;
         q.cold <= 1'b1;
         q.port_val <= wpr_pkg::PORT_RST;
         q.sp_val <= wpr_pkg::SP_RST;
         q.pwr.osc_run <= 1'b1;
      end else begin
         q <= n;
      end
   end

   assign apb_rsp = q.rsp;
   assign pwr = q.pwr;
   assign sys_reset = q.sys_rst;
   assign irq = q.irq;
   assign port_init_val = q.port_val;
   assign sp_init_val = q.sp_val;

   // Twelve oscillator clocks of reset, split so the repeat counts stay small.
   sequence seq_rst_first;
      q.sys_rst [*8];
   endsequence
   sequence seq_rst_rest;
      q.sys_rst [*4];
   endsequence

   AST_PRESC_WRAP: assert property (@(posedge clk) disable iff (reset)
      tick && !q.wd_restart && !q.sys_rst |=> q.presc == '0 &&
      q.wtimer == $past(q.wtimer) + 14'h0001)
      else $error("Prescaler wrap did not advance the timer.");
   AST_RESTART: assert property (@(posedge clk) disable iff (reset)
      q.wd_restart && mc_end && !wr |=> q.wtimer == '0 && q.presc == '0 && !q.wd_restart)
      else $error("Restart did not clear timer, prescaler and bit.");
   AST_SYSRST_CLEAR: assert property (@(posedge clk) disable iff (reset)
      q.sys_rst |=> q.wtimer == '0 && !q.wd_run)
      else $error("System reset left the watchdog running or counted.");
   AST_HALF_RATE: assert property (@(posedge clk) disable iff (reset)
      q.pwr.per_clk_en |=> !q.pwr.per_clk_en)
      else $error("Internal clock enable ran at the oscillator rate.");
   AST_LIGHT_GATE: assert property (@(posedge clk) disable iff (reset)
      q.mode == wpr_pkg::WPR_LIGHT |-> !q.pwr.cpu_clk_en && q.pwr.osc_run)
      else $error("Processor clocked during light sleep.");
   AST_WAKE: assert property (@(posedge clk) disable iff (reset)
      q.mode == wpr_pkg::WPR_LIGHT && irq_wake && !wr |=> q.mode == wpr_pkg::WPR_RUN)
      else $error("Interrupt did not end light sleep.");
   AST_DEEP_STOP: assert property (@(posedge clk) disable iff (reset)
      q.mode == wpr_pkg::WPR_DEEP |-> !q.pwr.osc_run && !q.pwr.per_clk_en)
      else $error("A clock ran during deep sleep.");
   AST_DEEP_STAY: assert property (@(posedge clk) disable iff (reset)
      q.mode == wpr_pkg::WPR_DEEP && !q.sys_rst |=> q.mode == wpr_pkg::WPR_DEEP)
      else $error("Deep sleep left without a reset.");
   AST_RST_VALUES: assert property (@(posedge clk) disable iff (reset)
      q.sys_rst |=> q.gflags == 2'h0 && q.wd_sel == 3'h0 && q.port_val == 8'hFF &&
      q.sp_val == 8'h07)
      else $error("Reset values not loaded.");
   AST_TIMEOUT_RST: assert property (@(posedge clk) disable iff (reset)
      timeout |=> q.sys_rst && q.stat[wpr_pkg::EV_TIMEOUT])
      else $error("Time-out did not raise the system reset.");
   AST_SLEEP_HALT: assert property (@(posedge clk) disable iff (reset)
      q.mode == wpr_pkg::WPR_LIGHT && !q.wd_sleep && !q.wd_restart && !q.sys_rst
      |=> q.wtimer == $past(q.wtimer))
      else $error("Watchdog counted in light sleep without permission.");
   AST_COLD_KEEP: assert property (@(posedge clk) disable iff (reset)
      q.sys_rst && !wr |=> q.cold == $past(q.cold))
      else $error("System reset changed the cold boot flag.");
   AST_HOLD_MC: assert property (@(posedge clk) disable iff (reset)
      timeout |=> seq_rst_first ##1 seq_rst_rest)
      else $error("Time-out reset shorter than one machine cycle.");
endmodule

// ### sim/wpr_far_model.sv
// Purpose: Far-side model: the external reset circuit and the interrupt source.
// Assumes: Requests change right after a rising edge of the bench clock.
// Notes: Both lines rest low, as a reset pin with a pull-down would.
`timescale 1ns/1ps
module wpr_far_model (
   input wire logic clk,
   output logic ext_rst,
   output logic irq_wake
);
   // Both lines start idle so the block never sees an unknown level.
   initial begin
      ext_rst = 1'b0;
      irq_wake = 1'b0;
   end
   // Holds the reset pin high for n clocks; short n makes a glitch on purpose.
   task automatic pulse_rst(input int n);
      begin
         @(posedge clk);
         ext_rst <= 1'b1;
         repeat (n) @(posedge clk);
         ext_rst <= 1'b0;
      end
   endtask
   // Raises one interrupt request for a single clock.
   task automatic wake();
      begin
         @(posedge clk);
         irq_wake <= 1'b1;
         @(posedge clk);
         irq_wake <= 1'b0;
      end
   endtask
endmodule

// ### sim/wpr_top_test.sv
// Purpose: Self-checking bench for the watchdog, sleep and reset block.
// Assumes: APB answer is taken at the rising edge; enables are counted at the falling edge.
// Notes: The full watchdog time-out is too long to run, so only its rate is checked.
`timescale 1ns/1ps
module wpr_top_test;
   logic clk = 1'b0; // Bench clock, 25 MHz.
   logic reset = 1'b1; // Power-on reset, held at start.
   wpr_pkg::wpr_apb_req_t req = '0; // APB request to the block.
   wpr_pkg::wpr_apb_rsp_t rsp; // APB answer from the block.
   wpr_pkg::wpr_pwr_t pwr; // Clock enables.
   logic sys_reset, irq, ext_rst, irq_wake;
   logic [7:0] port_v, sp_v;
   int n_mismatch = 0; // Mismatches seen.
   int checks_done = 0; // Comparisons made.
   logic [31:0] q; // Last read data.
   logic [31:0] q2; // Second read data.
   logic err; // Last error answer.
   int ncpu, nper;
   always #20 clk = ~clk;
   wpr_far_model u_far (.clk(clk), .ext_rst(ext_rst), .irq_wake(irq_wake));
   wpr_top u_dut (.clk(clk), .reset(reset), .apb_req(req), .apb_rsp(rsp), .ext_rst(ext_rst),
      .irq_wake(irq_wake), .pwr(pwr), .sys_reset(sys_reset), .irq(irq),
      .port_init_val(port_v), .sp_init_val(sp_v));
   // Prints the counts and the verdict, then stops the run.
   task automatic test_done();
      begin
         $display("checks %0d mismatches %0d", checks_done, n_mismatch);
         if (n_mismatch == 0 && checks_done > 0) begin
            $display("RESULT: PASS");
         end else begin
            $display("RESULT: FAIL");
         end
         $finish;
      end
   endtask
   // Counts one comparison and reports it if it failed.
   task automatic chk(input logic ok, input string m);
      begin
         checks_done++;
         if (ok !== 1'b1) begin
            n_mismatch++;
            $display("BAD %0t %s", $time, m);
         end
      end
   endtask
   // One APB transfer; the request stands until pready is seen high.
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int k;
      begin
         k = 0;
         @(posedge clk);
         req.psel <= 1'b1;
         req.penable <= 1'b0;
         req.pwrite <= wr;
         req.paddr <= a;
         req.pwdata <= d;
         @(posedge clk);
         req.penable <= 1'b1;
         // The answer is taken at the rising edge where pready is seen high.
         do begin
            @(posedge clk);
            k++;
         end while (rsp.pready !== 1'b1 && k < 20);
         chk(k < 20, "no pready");
         if (k >= 20) begin
            test_done();
         end
         q = rsp.prdata;
         err = rsp.pslverr;
         req.psel <= 1'b0;
         req.penable <= 1'b0;
      end
   endtask
   // Counts clock enables over n cycles.
   task automatic cnt_en(input int n);
      begin
         ncpu = 0;
         nper = 0;
         repeat (n) begin
            @(negedge clk);
            ncpu += (pwr.cpu_clk_en === 1'b1);
            nper += (pwr.per_clk_en === 1'b1);
         end
      end
   endtask
   // Waits a bounded time for sys_reset to reach v.
   task automatic wait_sys(input logic v, input int n);
      int k;
      begin
         k = 0;
         while (sys_reset !== v && k < n) begin
            @(negedge clk);
            k++;
         end
         chk(sys_reset === v, "sys_reset wait ran out");
         if (sys_reset !== v) begin
            test_done();
         end
      end
   endtask
   // Reset values, cold flag and an unmapped address.
   task automatic t_reset();
      begin
         chk(port_v === 8'hFF && sp_v === 8'h07, "init values");
         apb(1'b0, wpr_pkg::ADDR_PWR, 32'h0);
         chk(q === 32'h00000010, "power reg reset value");
         repeat (60) @(posedge clk);
         apb(1'b0, wpr_pkg::ADDR_COUNT, 32'h0);
         chk(q === 32'h0, "watchdog counts when off");
         apb(1'b0, 8'h20, 32'h0);
         chk(err === 1'b1 && q === 32'h0, "unmapped read");
         $display("reset test done");
      end
   endtask
   // Internal clock is the input clock divided by two.
   task automatic t_clock();
      begin
         cnt_en(24);
         chk(ncpu == 12 && nper == 12 && pwr.osc_run === 1'b1, "clk/2 enables");
         $display("clock test done");
      end
   endtask
   // Watchdog rate with divisor 2, then a restart.
   task automatic t_wdog();
      begin
         apb(1'b1, wpr_pkg::ADDR_WDOG, 32'h80);
         repeat (240) @(posedge clk);
         apb(1'b0, wpr_pkg::ADDR_COUNT, 32'h0);
         chk(q >= 32'd8 && q <= 32'd11, "count rate, one step per 24 clk");
         apb(1'b1, wpr_pkg::ADDR_WDOG, 32'hC0);
         repeat (14) @(posedge clk);
         apb(1'b0, wpr_pkg::ADDR_COUNT, 32'h0);
         chk(q <= 32'd1, "restart clears count");
         apb(1'b0, wpr_pkg::ADDR_WDOG, 32'h0);
         chk(q === 32'h80, "restart bit clears itself");
         $display("watchdog test done");
      end
   endtask
   // Light sleep halts the core and the watchdog; an interrupt wakes it.
   task automatic t_light();
      begin
         apb(1'b1, wpr_pkg::ADDR_MASK, 32'h4);
         apb(1'b1, wpr_pkg::ADDR_PWR, 32'h11);
         cnt_en(24);
         chk(ncpu == 0 && nper == 12, "light sleep enables");
         apb(1'b0, wpr_pkg::ADDR_COUNT, 32'h0);
         q2 = q;
         repeat (240) @(posedge clk);
         apb(1'b0, wpr_pkg::ADDR_COUNT, 32'h0);
         chk(q === q2, "watchdog halted in light sleep");
         u_far.wake();
         repeat (2) @(posedge clk);
         cnt_en(12);
         chk(ncpu == 6 && irq === 1'b1, "wake by interrupt");
         apb(1'b1, wpr_pkg::ADDR_STAT, 32'h4);
         repeat (2) @(posedge clk);
         chk(irq === 1'b0, "status cleared by one");
         $display("light sleep test done");
      end
   endtask
   // Deep sleep: only a held, clean reset pin ends it.
   task automatic t_deep();
      begin
         apb(1'b1, wpr_pkg::ADDR_PWR, 32'h2);
         repeat (4) @(posedge clk);
         chk(pwr.osc_run === 1'b0, "oscillator stopped");
         u_far.wake();
         cnt_en(24);
         chk(ncpu == 0 && nper == 0 && pwr.osc_run === 1'b0, "interrupt ignored");
         fork
            u_far.pulse_rst(2);
            cnt_en(40);
         join
         chk(sys_reset === 1'b0 && pwr.osc_run === 1'b0, "glitch ignored");
         fork
            u_far.pulse_rst(36);
            wait_sys(1'b1, 60);
         join
         wait_sys(1'b0, 60);
         repeat (4) @(posedge clk);
         chk(pwr.osc_run === 1'b1, "reset ends deep sleep");
         apb(1'b0, wpr_pkg::ADDR_WDOG, 32'h0);
         chk(q === 32'h0, "watchdog off after reset");
         apb(1'b0, wpr_pkg::ADDR_COUNT, 32'h0);
         chk(q === 32'h0, "count cleared by reset");
         apb(1'b0, wpr_pkg::ADDR_PWR, 32'h0);
         chk(q === 32'h0, "cold flag kept clear");
         $display("deep sleep test done");
      end
   endtask
   // Main sequence.
   initial begin
      repeat (3) @(posedge clk);
      reset <= 1'b0;
      @(posedge clk);
      t_reset();
      t_clock();
      t_wdog();
      t_light();
      t_deep();
      test_done();
   end
   // Cuts a hang short.
   initial begin
      repeat (90000) @(posedge clk);
      n_mismatch++;
      test_done();
   end
endmodule
